// file: hw/lub_pkg.sv
package lub_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_DATA = 12'hf40;
  localparam logic [11:0] ADDR_STAT0 = 12'hf41;
  localparam logic [11:0] ADDR_CTL0 = 12'hf42;
  localparam logic [11:0] ADDR_CTL1 = 12'hf43;
  localparam logic [11:0] ADDR_MODE = 12'hf44;
  localparam logic [11:0] ADDR_NODE = 12'hf45;
  localparam logic [11:0] ADDR_BRH = 12'hf46;
  localparam logic [11:0] ADDR_BRL = 12'hf47;
  localparam logic [2:0] PAGE_MPROC = 3'h0;
  localparam logic [2:0] PAGE_FILT = 3'h1;
  localparam int CT0_TEN = 7;
  localparam int CT0_REN = 6;
  localparam int CT0_PEN = 5;
  localparam int CT0_PSEL = 4;
  localparam int CT0_LIN = 0;
  localparam int CT1_MULTIPROC_ADDRESSING_ENABLE = 7;
  localparam int CT1_RX_AVAIL_IRQ_ENABLE = 1;
  localparam int CT1_DIVISOR_TIMER_CONTROL = 0;
  localparam int CT1_FILTER_ENABLE = 7;
  localparam int CT1_NFW_LSB = 4;
  localparam int MODE_PAGE_LSB = 5;
  localparam logic [15:0] DIV_RESET = 16'h0002;
  localparam logic [3:0] OVS_SHIFT = 4'h4;
  localparam logic [3:0] BITS_PLAIN = 4'h8;
  localparam logic [3:0] BITS_EXTRA = 4'h9;
  localparam logic [2:0] NF_WIDTH_RESET = 3'h0;
  localparam logic [10:0] NF_CNT_FULL = 11'h7ff;
  typedef enum logic [1:0] {
    LUB_IDLE = 2'h0,
    LUB_START = 2'h1,
    LUB_DATA = 2'h3,
    LUB_STOP = 2'h2
  } lub_frame_t;
endpackage : lub_pkg

// file: hw/lub_if.sv
`timescale 1ns/10ps
interface lub_brg_if;
  logic [15:0] divisor;
  logic whole_bit;
  logic restart;
  logic bit_tick;
  logic mid_tick;
  modport gen (input divisor, input whole_bit, input restart, output bit_tick, output mid_tick);
  modport user (output divisor, output whole_bit, output restart, input bit_tick, input mid_tick);
endinterface : lub_brg_if

interface lub_nf_if;
  logic enable;
  logic [2:0] width_sel;
  logic rx_pin;
  logic rx_out;
  logic sat_n;
  modport filt (input enable, input width_sel, input rx_pin, output rx_out, output sat_n);
  modport user (output enable, output width_sel, output rx_pin, input rx_out, input sat_n);
endinterface : lub_nf_if

// file: hw/lub_brg.sv
`timescale 1ns/10ps
module lub_brg (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  lub_brg_if.gen brg      // Divisor in, ticks out
);
  import lub_pkg::*;
  typedef struct packed {
    logic [19:0] cnt;
  } lub_brg_st_t;
  lub_brg_st_t st_r;
  lub_brg_st_t st_nxt;
  logic [19:0] period;

  always_comb begin
    // Period is the divisor in LIN or timer use, sixteen times the divisor otherwise
    period = brg.whole_bit ? {4'h0, brg.divisor} : ({4'h0, brg.divisor} << OVS_SHIFT);
    if (period == 20'h0) begin
      period = 20'h1;
    end
    brg.bit_tick = st_r.cnt >= period - 20'h1;
    brg.mid_tick = st_r.cnt == (period >> 1);
    st_nxt.cnt = (brg.restart || brg.bit_tick) ? 20'h0 : st_r.cnt + 20'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : lub_brg

// file: hw/lub_nfilt.sv
`timescale 1ns/10ps
module lub_nfilt (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  lub_nf_if.filt nf       // Filter controls and data
);
  import lub_pkg::*;
  typedef struct packed {
    logic [1:0] sync;
    logic [10:0] cnt;
    logic out;
    logic sat_n;
  } lub_nf_st_t;
  lub_nf_st_t st_r;
  lub_nf_st_t st_nxt;
  logic [10:0] mask;
  logic s;

  always_comb begin
    st_nxt = st_r;
    mask = NF_CNT_FULL >> (3'h7 - nf.width_sel);
    s = st_r.sync[1];
    st_nxt.sync = {st_r.sync[0], nf.rx_pin};
    if (st_r.cnt > mask) begin
      st_nxt.cnt = mask;
    end else if (s && st_r.cnt != mask) begin
      st_nxt.cnt = st_r.cnt + 11'h1;
    end else if (!s && st_r.cnt != 11'h0) begin
      st_nxt.cnt = st_r.cnt - 11'h1;
    end
    if (!nf.enable) begin
      st_nxt.out = s;
    end else if (s && st_r.cnt == mask - 11'h1) begin
      st_nxt.out = 1'b1;
    end else if (!s && st_r.cnt == 11'h1) begin
      st_nxt.out = 1'b0;
    end
    st_nxt.sat_n = nf.enable && st_nxt.cnt != 11'h0 && st_nxt.cnt != mask;
  end

  assign nf.rx_out = st_r.out;
  assign nf.sat_n = st_r.sat_n;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{sync: 2'h3, cnt: NF_CNT_FULL, out: 1'b1, sat_n: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  a_nf_bypass_lat: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(nf.enable) |-> nf.rx_out == $past(nf.rx_pin, 3)) else $error("bypass latency not three");
  a_nf_rise_full: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(nf.rx_out) && $past(nf.enable) |-> st_r.cnt == mask) else $error("filter rose early");
endmodule : lub_nfilt

// file: hw/lub_top.sv
// Behaviour
// - Transmit interrupt follows the transmit-holding-empty flag.
// - Empty flag sets on transmitter enable and after each start bit.
// - Writing the transmit holding byte clears the empty flag, except in the cycle a start bit ends.
// - Data-available interrupt after byte stored, own enable bit.
// - Receiver interrupt also on break, overrun, framing, parity errors.
// - Multiprocessor mode gates data interrupts by last address byte.
// - Overrun keeps held byte, hides overrun and break until read.
// - After that read, overrun and available set, break shows cause.
// - Second data read after overrun status clears error bits.
// - Autobaud overflow sets overrun and timeout; data read clears.
// - Timer mode with receiver off: receiver interrupt per reload.
// - Divider clocked by system clock, 16-bit divisor from two bytes.
// - Normal rate clock over sixteen times divisor, LIN over divisor.
// - Filter synchronises input; enable inserts it, otherwise bypassed.
// - Three-bit select sets counter width from 4 to 11.
// - Output falls entering all-zeros, rises entering all-ones.
// - Bypassed filter adds three clocks of latency.
// - Active-low saturated output high when filter enabled and counter not saturated.
// - Unsaturated filter at mid-bit sample sets the noise event flag.
// - Transmit byte shares address with receive byte, goes out serially.
// - Data read clears available, parity, overrun, framing, break.
`timescale 1ns/10ps
module lub_top (
  input wire logic CLOCK_I,                      // System clock
  input wire logic RESET_I,                      // Synchronous reset
  input wire logic [lub_pkg::ADDR_W-1:0] ADDR_I, // Register address
  input wire logic [7:0] WDATA_I,                // Write data
  input wire logic WR_I,                         // Write strobe
  input wire logic RD_I,                         // Read strobe
  output logic [7:0] RDATA_O,                    // Read data, next cycle
  input wire logic RXD_I,                        // Serial receive pin
  output logic TXD_O,                            // Serial transmit pin
  input wire logic AUTOBAUD_OVF_I,               // Autobaud counter overflow pulse
  output logic TX_IRQ_O,                         // Transmitter interrupt
  output logic RX_IRQ_O                          // Receiver interrupt
);
  import lub_pkg::*;
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] tx_hold;
    logic [8:0] tx_shift;
    logic [8:0] rx_shift;
    lub_frame_t rx_st;
    lub_frame_t tx_st;
    logic [3:0] rx_cnt;
    logic [3:0] tx_cnt;
    logic rx_byte_available;
    logic pe;
    logic oe;
    logic fe;
    logic line_break_flag;
    logic autobaud_timeout_flag;
    logic tx_holding_empty;
    logic ovr_pend;
    logic brk_pend;
    logic ne;
    logic tmr_flag;
    logic transmitter_enable;
    logic ren;
    logic pen;
    logic psel;
    logic lin;
    logic [2:0] page;
    logic multiproc_addressing_enable;
    logic rx_avail_irq_enable;
    logic divisor_timer_control;
    logic nf_en;
    logic [2:0] nf_w;
    logic [7:0] node;
    logic [15:0] div;
    logic mp_match;
    logic irq_ok;
    logic [7:0] rdata;
    logic txd;
  } lub_state_t;
  lub_state_t st_r;
  lub_state_t st_nxt;

  lub_brg_if tx_brg ();
  lub_brg_if rx_brg ();
  lub_nf_if nf ();

  lub_brg u_tx_brg (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .brg(tx_brg)
  );
  lub_brg u_rx_brg (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .brg(rx_brg)
  );
  lub_nfilt u_nfilt (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .nf(nf)
  );

  logic wr_data;
  logic rd_data;
  logic rd_stat;
  logic rd_mode;
  logic rxf;
  logic nine;
  logic [3:0] nbits;
  logic rx_done;
  logic rx_full;
  logic rx_brk;
  logic sample_now;
  logic tmr_mode;
  logic tx_first;
  logic ctl0_wr;
  logic [7:0] rx_byte;

  assign wr_data = WR_I && ADDR_I == ADDR_DATA;
  assign rd_data = RD_I && ADDR_I == ADDR_DATA;
  assign rd_stat = RD_I && ADDR_I == ADDR_STAT0;
  assign rd_mode = RD_I && ADDR_I == ADDR_MODE;
  assign ctl0_wr = WR_I && ADDR_I == ADDR_CTL0;
  assign rxf = nf.rx_out;
  assign nine = st_r.pen || st_r.multiproc_addressing_enable;
  assign nbits = nine ? BITS_EXTRA : BITS_PLAIN;
  assign tmr_mode = st_r.divisor_timer_control && !st_r.ren;
  assign sample_now = rx_brg.mid_tick && st_r.rx_st != LUB_IDLE;
  assign rx_done = rx_brg.mid_tick && st_r.rx_st == LUB_STOP;
  assign rx_full = st_r.rx_byte_available && !rd_data;
  assign rx_byte = nine ? st_r.rx_shift[7:0] : st_r.rx_shift[8:1];
  assign rx_brk = !rxf && (nine ? st_r.rx_shift == 9'h0 : st_r.rx_shift[8:1] == 8'h0);
  assign tx_first = tx_brg.bit_tick && st_r.tx_st == LUB_START;

  assign tx_brg.divisor = st_r.div;
  assign tx_brg.whole_bit = st_r.lin;
  assign tx_brg.restart = st_r.tx_st == LUB_IDLE;
  assign rx_brg.divisor = st_r.div;
  assign rx_brg.whole_bit = st_r.lin || tmr_mode;
  assign rx_brg.restart = st_r.ren && st_r.rx_st == LUB_IDLE && rxf;
  assign nf.enable = st_r.nf_en;
  assign nf.width_sel = st_r.nf_w;
  assign nf.rx_pin = RXD_I;

  always_comb begin
    st_nxt = st_r;
    // Register writes
    if (wr_data) begin
      st_nxt.tx_hold = WDATA_I;
      st_nxt.tx_holding_empty = 1'b0;
    end
    if (ctl0_wr) begin
      st_nxt.transmitter_enable = WDATA_I[CT0_TEN];
      st_nxt.ren = WDATA_I[CT0_REN];
      st_nxt.pen = WDATA_I[CT0_PEN];
      st_nxt.psel = WDATA_I[CT0_PSEL];
      st_nxt.lin = WDATA_I[CT0_LIN];
      if (WDATA_I[CT0_TEN] && !st_r.transmitter_enable) begin
        st_nxt.tx_holding_empty = 1'b1;
      end
    end
    if (WR_I && ADDR_I == ADDR_CTL1 && st_r.page == PAGE_MPROC) begin
      st_nxt.multiproc_addressing_enable = WDATA_I[CT1_MULTIPROC_ADDRESSING_ENABLE];
      st_nxt.rx_avail_irq_enable = WDATA_I[CT1_RX_AVAIL_IRQ_ENABLE];
      st_nxt.divisor_timer_control = WDATA_I[CT1_DIVISOR_TIMER_CONTROL];
    end
    if (WR_I && ADDR_I == ADDR_CTL1 && st_r.page == PAGE_FILT) begin
      st_nxt.nf_en = WDATA_I[CT1_FILTER_ENABLE];
      st_nxt.nf_w = WDATA_I[CT1_NFW_LSB+2:CT1_NFW_LSB];
    end
    if (WR_I && ADDR_I == ADDR_MODE) begin
      st_nxt.page = WDATA_I[MODE_PAGE_LSB+2:MODE_PAGE_LSB];
    end
    if (WR_I && ADDR_I == ADDR_NODE) begin
      st_nxt.node = WDATA_I;
    end
    if (WR_I && ADDR_I == ADDR_BRH) begin
      st_nxt.div[15:8] = WDATA_I;
    end
    if (WR_I && ADDR_I == ADDR_BRL) begin
      st_nxt.div[7:0] = WDATA_I;
    end
    // Read side effects, clears come before hardware sets
    if (rd_data) begin
      if (st_r.ovr_pend) begin
        st_nxt.rx_byte_available = 1'b1;
        st_nxt.oe = 1'b1;
        st_nxt.line_break_flag = st_r.brk_pend;
        st_nxt.pe = 1'b0;
        st_nxt.fe = 1'b0;
        st_nxt.ovr_pend = 1'b0;
        st_nxt.brk_pend = 1'b0;
      end else begin
        {st_nxt.rx_byte_available, st_nxt.pe, st_nxt.oe, st_nxt.fe, st_nxt.line_break_flag, st_nxt.autobaud_timeout_flag} = 6'h0;
      end
    end
    if (rd_stat) begin
      st_nxt.tmr_flag = 1'b0;
    end
    if (rd_mode) begin
      st_nxt.ne = 1'b0;
    end
    // Transmitter
    unique case (st_r.tx_st)
      LUB_IDLE: begin
        if (st_r.transmitter_enable && !st_r.tx_holding_empty) begin
          // Ninth bit is parity only when parity is on, else 0 as the address-mark slot
          st_nxt.tx_shift = {st_r.pen & ((^st_r.tx_hold) ^ st_r.psel), st_r.tx_hold};
          st_nxt.tx_st = LUB_START;
        end
      end
      LUB_START: begin
        if (tx_brg.bit_tick) begin
          st_nxt.tx_holding_empty = 1'b1;
          st_nxt.tx_cnt = 4'h0;
          st_nxt.tx_st = LUB_DATA;
        end
      end
      LUB_DATA: begin
        if (tx_brg.bit_tick) begin
          st_nxt.tx_shift = {1'b1, st_r.tx_shift[8:1]};
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          if (st_r.tx_cnt == nbits - 4'h1) begin
            st_nxt.tx_st = LUB_STOP;
          end
        end
      end
      LUB_STOP: begin
        if (tx_brg.bit_tick) begin
          st_nxt.tx_st = LUB_IDLE;
        end
      end
    endcase
    st_nxt.txd = st_nxt.tx_st == LUB_START ? 1'b0 : (st_nxt.tx_st == LUB_DATA ? st_nxt.tx_shift[0] : 1'b1);
    // Receiver
    unique case (st_r.rx_st)
      LUB_IDLE: begin
        if (st_r.ren && !rxf) begin
          st_nxt.rx_st = LUB_START;
        end
      end
      LUB_START: begin
        if (rx_brg.mid_tick) begin
          st_nxt.rx_cnt = 4'h0;
          st_nxt.rx_st = rxf ? LUB_IDLE : LUB_DATA;
        end
      end
      LUB_DATA: begin
        if (rx_brg.mid_tick) begin
          st_nxt.rx_shift = {rxf, st_r.rx_shift[8:1]};
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          if (st_r.rx_cnt == nbits - 4'h1) begin
            st_nxt.rx_st = LUB_STOP;
          end
        end
      end
      LUB_STOP: begin
        if (rx_brg.mid_tick) begin
          st_nxt.rx_st = LUB_IDLE;
        end
      end
    endcase
    if (!st_r.ren) begin
      st_nxt.rx_st = LUB_IDLE;
    end
    if (sample_now && nf.sat_n) begin
      st_nxt.ne = 1'b1;
    end
    if (rx_done) begin
      if (rx_full) begin
        st_nxt.ovr_pend = 1'b1;
        st_nxt.brk_pend = rx_brk;
      end else begin
        st_nxt.rx_data = rx_byte;
        st_nxt.rx_byte_available = 1'b1;
        st_nxt.pe = st_r.pen && ((^st_r.rx_shift) != st_r.psel);
        st_nxt.fe = !rxf;
        st_nxt.line_break_flag = rx_brk;
        st_nxt.irq_ok = !st_r.multiproc_addressing_enable || st_r.rx_shift[8] || st_r.mp_match;
        if (st_r.multiproc_addressing_enable && st_r.rx_shift[8]) begin
          st_nxt.mp_match = rx_byte == st_r.node;
          st_nxt.irq_ok = rx_byte == st_r.node;
        end
      end
    end
    if (AUTOBAUD_OVF_I) begin
      st_nxt.oe = 1'b1;
      st_nxt.autobaud_timeout_flag = 1'b1;
    end
    if (tmr_mode && rx_brg.bit_tick) begin
      st_nxt.tmr_flag = 1'b1;
    end
    // Read data
    if (RD_I) begin
      unique case (ADDR_I)
        ADDR_DATA: st_nxt.rdata = st_r.rx_data;
        ADDR_STAT0: st_nxt.rdata = {st_r.rx_byte_available, st_r.pe, st_r.oe, st_r.fe, st_r.line_break_flag, st_r.tx_holding_empty,
                                    st_r.tx_holding_empty && st_r.tx_st == LUB_IDLE, st_r.lin && st_r.autobaud_timeout_flag};
        ADDR_CTL0: st_nxt.rdata = {st_r.transmitter_enable, st_r.ren, st_r.pen, st_r.psel, 3'h0, st_r.lin};
        ADDR_CTL1: st_nxt.rdata = st_r.page == PAGE_MPROC ? {st_r.multiproc_addressing_enable, 5'h0, st_r.rx_avail_irq_enable, st_r.divisor_timer_control} :
                                  (st_r.page == PAGE_FILT ? {st_r.nf_en, st_r.nf_w, 4'h0} : 8'h0);
        ADDR_MODE: st_nxt.rdata = {st_r.page, 4'h0, st_r.ne};
        ADDR_NODE: st_nxt.rdata = st_r.node;
        ADDR_BRH: st_nxt.rdata = st_r.div[15:8];
        ADDR_BRL: st_nxt.rdata = st_r.div[7:0];
        default: st_nxt.rdata = 8'h0;
      endcase
    end
  end

  assign RDATA_O = st_r.rdata;
  assign TXD_O = st_r.txd;
  assign TX_IRQ_O = st_r.tx_holding_empty;
  assign RX_IRQ_O = (st_r.rx_byte_available && st_r.rx_avail_irq_enable && st_r.irq_ok) || st_r.pe || st_r.oe || st_r.fe || st_r.line_break_flag ||
                    st_r.tmr_flag;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      st_r <= '0;
      st_r.tx_holding_empty <= 1'b1;
      st_r.txd <= 1'b1;
      st_r.div <= DIV_RESET;
      st_r.nf_w <= NF_WIDTH_RESET;
      st_r.irq_ok <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  a_tx_holding_empty_write_clr: assert property (wr_data && !tx_first |=> !st_r.tx_holding_empty) else $error("write left empty set");
  a_tx_holding_empty_first_bit: assert property (tx_first |=> st_r.tx_holding_empty ##0 TX_IRQ_O) else $error("empty not set");
  a_tx_irq_cause: assert property ($rose(TX_IRQ_O) |-> $past(tx_first) || $past(ctl0_wr))
    else $error("tx irq without cause");
  a_ovr_keep_data: assert property (rx_done && rx_full |=> $stable(st_r.rx_data) && st_r.ovr_pend)
    else $error("overrun overwrote data");
  a_ovr_reveal: assert property (rd_data && st_r.ovr_pend |=> st_r.rx_byte_available && st_r.oe ##1 RX_IRQ_O)
    else $error("overrun not shown");
  a_read_clears: assert property (rd_data && !st_r.ovr_pend && !rx_done && !AUTOBAUD_OVF_I |=>
    !st_r.rx_byte_available && !st_r.oe && !st_r.pe && !st_r.fe && !st_r.line_break_flag) else $error("read did not clear");
  a_autobaud_ovf: assert property (AUTOBAUD_OVF_I |=> st_r.oe && st_r.autobaud_timeout_flag && RX_IRQ_O)
    else $error("autobaud overflow lost");
  a_timer_reload: assert property (tmr_mode && rx_brg.bit_tick |=> RX_IRQ_O) else $error("no timer irq");
  a_noise_flag: assert property (sample_now && nf.sat_n |=> st_r.ne) else $error("noise not flagged");
  a_err_irq: assert property (st_r.pe || st_r.fe || st_r.line_break_flag |-> RX_IRQ_O) else $error("error irq missing");
endmodule : lub_top

// file: dv/lub_node.sv
`timescale 1ns/10ps
module lub_node (
  input wire logic clk_i, // System clock
  input wire logic txd_i, // Line from the block
  output logic rxd_o      // Line into the block
);
  int bit_clks = 32;
  logic [7:0] got_q[$];
  logic [7:0] d;
  initial rxd_o = 1'b1;
  // Start, data LSB first, optional ninth bit, stop; break holds all low
  task automatic send(input logic [8:0] b, input logic nine_en, input logic brk, input logic glitch);
    logic [10:0] f;
    int n;
    f = nine_en ? {1'b1, b, 1'b0} : {2'b11, b[7:0], 1'b0};
    if (brk) begin
      f = 11'h0;
    end
    n = nine_en ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < bit_clks; c++) begin
        @(posedge clk_i);
        rxd_o <= f[i] ^ (glitch && i > 0 && i < 9 && c >= bit_clks / 2 && c < bit_clks / 2 + 10);
      end
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask : send
  // Mid-bit sampling of frames sent by the block
  initial forever begin
    @(negedge txd_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      d[i] = txd_i;
    end
    repeat (bit_clks) @(posedge clk_i);
    if (txd_i) begin
      got_q.push_back(d);
    end
  end
endmodule : lub_node

// file: dv/lin_uart_irq_brg_noise_filter_tb.sv
`timescale 1ns/10ps
module lin_uart_irq_brg_noise_filter_tb;
  import lub_pkg::*;
  logic clk, rst, wr, rd, rxd, txd, abovf, tx_irq, rx_irq;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [8:0] mp_f [5] = '{9'h055, 9'h112, 9'h077, 9'h134, 9'h066};
  logic [4:0] mp_i = 5'b00100;
  int miscompares = 0;
  int compares = 0;
  lub_top u_dut (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd), .AUTOBAUD_OVF_I(abovf), .TX_IRQ_O(tx_irq), .RX_IRQ_O(rx_irq));
  lub_node u_node (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask : chk_bit
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic exp_reg(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    rd_reg(a);
    chk_byte(v & m, e);
  endtask : exp_reg
  task automatic rx_frame(input logic [8:0] b, input logic ne, input logic brk, input logic gl);
    u_node.send(b, ne, brk, gl);
    repeat (8) @(posedge clk);
    #1;
  endtask : rx_frame
  task automatic wait_tx(input int n);
    for (int k = 0; k < 4000 && u_node.got_q.size() < n; k++) @(posedge clk);
    repeat (40) @(posedge clk);
  endtask : wait_tx
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic finish_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h0;
    wdata = 8'h0;
    abovf = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_bit(tx_irq, 1'b1);
    chk_bit(rx_irq, 1'b0);
    exp_reg(ADDR_STAT0, 8'hff, 8'h06);
    exp_reg(12'hf4f, 8'hff, 8'h00);
    done("reset");
    wr_reg(ADDR_CTL0, 8'h80);
    wr_reg(ADDR_DATA, 8'ha5);
    #1;
    chk_bit(tx_irq, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    chk_bit(tx_irq, 1'b0);
    repeat (28) @(posedge clk);
    #1;
    chk_bit(tx_irq, 1'b1);
    wr_reg(ADDR_DATA, 8'h3c);
    wait_tx(2);
    chk_byte(u_node.got_q[0], 8'ha5);
    chk_byte(u_node.got_q[1], 8'h3c);
    wr_reg(ADDR_CTL0, 8'h81);
    wr_reg(ADDR_BRH, 8'h01);
    wr_reg(ADDR_BRL, 8'h00);
    u_node.bit_clks = 256;
    wr_reg(ADDR_DATA, 8'h96);
    wait_tx(3);
    chk_byte(u_node.got_q[2], 8'h96);
    wr_reg(ADDR_BRH, 8'h00);
    wr_reg(ADDR_BRL, 8'h02);
    u_node.bit_clks = 32;
    wr_reg(ADDR_CTL0, 8'hc0);
    done("tx");
    wr_reg(ADDR_MODE, 8'h00);
    wr_reg(ADDR_CTL1, 8'h02);
    rx_frame(9'h03c, 0, 0, 0);
    chk_bit(rx_irq, 1'b1);
    exp_reg(ADDR_STAT0, 8'hf8, 8'h80);
    exp_reg(ADDR_DATA, 8'hff, 8'h3c);
    chk_bit(rx_irq, 1'b0);
    wr_reg(ADDR_CTL1, 8'h00);
    rx_frame(9'h0c3, 0, 0, 0);
    chk_bit(rx_irq, 1'b0);
    exp_reg(ADDR_STAT0, 8'h80, 8'h80);
    exp_reg(ADDR_DATA, 8'hff, 8'hc3);
    done("rx");
    wr_reg(ADDR_CTL1, 8'h02);
    rx_frame(9'h011, 0, 0, 0);
    rx_frame(9'h022, 0, 0, 0);
    exp_reg(ADDR_STAT0, 8'hf8, 8'h80);
    exp_reg(ADDR_DATA, 8'hff, 8'h11);
    chk_bit(rx_irq, 1'b1);
    exp_reg(ADDR_STAT0, 8'hf8, 8'ha0);
    rd_reg(ADDR_DATA);
    exp_reg(ADDR_STAT0, 8'hf8, 8'h00);
    rx_frame(9'h000, 0, 1, 0);
    chk_bit(rx_irq, 1'b1);
    exp_reg(ADDR_STAT0, 8'h18, 8'h18);
    rd_reg(ADDR_DATA);
    rx_frame(9'h033, 0, 0, 0);
    rx_frame(9'h000, 0, 1, 0);
    rd_reg(ADDR_DATA);
    exp_reg(ADDR_STAT0, 8'ha8, 8'ha8);
    rd_reg(ADDR_DATA);
    done("overrun");
    wr_reg(ADDR_CTL0, 8'he0);
    rx_frame(9'h001, 1, 0, 0);
    chk_bit(rx_irq, 1'b1);
    exp_reg(ADDR_STAT0, 8'h40, 8'h40);
    rd_reg(ADDR_DATA);
    rx_frame(9'h101, 1, 0, 0);
    exp_reg(ADDR_STAT0, 8'h40, 8'h00);
    rd_reg(ADDR_DATA);
    wr_reg(ADDR_CTL0, 8'hc0);
    wr_reg(ADDR_NODE, 8'h12);
    wr_reg(ADDR_CTL1, 8'h82);
    for (int k = 0; k < 5; k++) begin
      rx_frame(mp_f[k], 1, 0, 0);
      if (!mp_f[k][8]) begin
        chk_bit(rx_irq, mp_i[k]);
      end
      rd_reg(ADDR_DATA);
    end
    wr_reg(ADDR_CTL1, 8'h00);
    done("parity_mproc");
    wr_reg(ADDR_CTL0, 8'hc1);
    @(posedge clk);
    abovf <= 1'b1;
    @(posedge clk);
    abovf <= 1'b0;
    #1;
    chk_bit(rx_irq, 1'b1);
    exp_reg(ADDR_STAT0, 8'h21, 8'h21);
    rd_reg(ADDR_DATA);
    exp_reg(ADDR_STAT0, 8'h21, 8'h00);
    done("autobaud");
    wr_reg(ADDR_CTL0, 8'h80);
    wr_reg(ADDR_BRL, 8'h04);
    wr_reg(ADDR_CTL1, 8'h01);
    repeat (3) begin
      rd_reg(ADDR_STAT0);
      repeat (6) @(posedge clk);
      #1;
      chk_bit(rx_irq, 1'b1);
    end
    wr_reg(ADDR_CTL0, 8'hc0);
    rd_reg(ADDR_STAT0);
    repeat (20) @(posedge clk);
    #1;
    chk_bit(rx_irq, 1'b0);
    wr_reg(ADDR_CTL1, 8'h00);
    done("timer");
    u_node.bit_clks = 64;
    wr_reg(ADDR_MODE, 8'h20);
    wr_reg(ADDR_CTL1, 8'h80);
    rx_frame(9'h05a, 0, 0, 1);
    exp_reg(ADDR_DATA, 8'hff, 8'h5a);
    exp_reg(ADDR_MODE, 8'hff, 8'h21);
    exp_reg(ADDR_MODE, 8'hff, 8'h20);
    rx_frame(9'h0a5, 0, 0, 0);
    exp_reg(ADDR_MODE, 8'hff, 8'h20);
    exp_reg(ADDR_DATA, 8'hff, 8'ha5);
    wr_reg(ADDR_CTL1, 8'h00);
    rx_frame(9'h05a, 0, 0, 1);
    exp_reg(ADDR_MODE, 8'hff, 8'h20);
    rd_reg(ADDR_DATA);
    done("filter");
    finish_test;
  end
endmodule : lin_uart_irq_brg_noise_filter_tb
